// ---- shared/sdme_pkg.sv ----
// Overview of operation
// - safety code: bit1 inverse angle, bit0 field
// - application class maps to sensor type codes
// - protocol version field maps to revision code
// - supply message carries 9-bit voltage value
// - temperature message carries 8-bit value
// - channel index bit sends 000h or fffh
// - eight customer words sent unchanged, ids 90h-97h
// - maker code message is fixed, not programmable
// - status bit0 set while in diagnostic mode
// - mask bit forces diagnostic flag to zero
// - status bit1 pre-warning while in normal mode
// - mask bit forces pre-warning bit to zero
// - diagnostic mode substitutes fast data per format
// - status code sent only with slow channel enabled
// - frame crc excludes the status nibble
// - data nibbles keep angle despite the pre-warning flag
// - message spread over 18 frames, bits 2-3
// - fixed 18-message cycle repeated while enabled
// - diagnostic status code values and priority
package sdme_pkg;
   // message ids of the slow channel
   localparam logic [7:0] ID_DIAG   = 8'h01;
   localparam logic [7:0] ID_TYPE   = 8'h03;
   localparam logic [7:0] ID_MAKER  = 8'h05;
   localparam logic [7:0] ID_REV    = 8'h06;
   localparam logic [7:0] ID_SUPPLY = 8'h1c;
   localparam logic [7:0] ID_TEMP   = 8'h23;
   localparam logic [7:0] ID_CHAN   = 8'h29;
   localparam logic [7:0] ID_CUST0  = 8'h90;
   // maker code, value is arbitrary
   localparam logic [11:0] MAKER_CODE = 12'h5a5;
   // diagnostic status codes
   localparam logic [11:0] DC_NONE   = 12'h000;
   localparam logic [11:0] DC_OOR_HI = 12'h001;
   localparam logic [11:0] DC_OOR_LO = 12'h002;
   localparam logic [11:0] DC_UNDERV = 12'h020;
   localparam logic [11:0] DC_OVERV  = 12'h021;
   localparam logic [11:0] DC_OVERT  = 12'h022;
   localparam logic [11:0] DC_EDC    = 12'h023;
   // clamps and fast-channel diagnostic values
   localparam logic [11:0] SUPPLY_MAX = 12'h1ff;
   localparam logic [11:0] TEMP_MAX   = 12'h0ff;
   localparam logic [11:0] FAST_DIAG_A1 = 12'd4095;
   localparam logic [11:0] FAST_DIAG_H  = 12'd4090;
   // channel index codes
   localparam logic [11:0] CHAN_CODE0 = 12'h000;
   localparam logic [11:0] CHAN_CODE1 = 12'hfff;
   // frame and cycle lengths
   localparam logic [4:0] FRAMES_PER_MSG = 5'd18;
   localparam logic [4:0] MSGS_PER_CYCLE = 5'd18;
   // status nibble bit positions
   localparam int ST_DIAG = 0;
   localparam int ST_WARN = 1;
   localparam int ST_SER_DATA = 2;
   localparam int ST_SER_SYNC = 3;
   // fifo shape
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 16;
   // fast-channel protocol formats, one-hot
   typedef enum logic [4:0] {
      FMT_A1 = 5'b00001,
      FMT_A3 = 5'b00010,
      FMT_H1 = 5'b00100,
      FMT_H3 = 5'b01000,
      FMT_H4 = 5'b10000
   } sdme_fmt_type;
   // encoder state
   typedef struct packed {
      logic        pending;   // frame request waiting for fifo room
      logic [4:0]  frame_idx; // frame within the current message
      logic [4:0]  msg_idx;   // message within the cycle
      logic [7:0]  msg_id;    // latched id of message in flight
      logic [11:0] msg_data;  // latched data of message in flight
   } sdme_state_type;
endpackage : sdme_pkg

// ---- hw/sdme_encoder.sv ----
`timescale 1ns/1ps
`default_nettype none

// small synchronous fifo; flags are registered so the ports come from flops
module sdme_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   // depth must be a power of two so the pointers wrap by themselves
   localparam int AW = $clog2(DEPTH);
   // fifo state packed in one struct
   typedef struct packed {
      logic [AW-1:0] wr;     // write pointer
      logic [AW-1:0] rd;     // read pointer
      logic [AW:0]   cnt;    // fill level
      logic          nfull;  // room left
      logic          nempty; // data held
   } sdme_fifo_st_type;
   sdme_fifo_st_type   st_q, st_d;
   logic [WIDTH-1:0]   mem_q [DEPTH];    // storage words
   logic               push;             // word accepted
   logic               pop;              // word drained
   logic [AW:0]        cnt_n;            // level after this cycle

   // pointer and level bookkeeping
   always_comb begin
      push  = in_valid_i & st_q.nfull;
      pop   = out_ready_i & st_q.nempty;
      st_d  = st_q;
      // level kept apart from the pointers so full and empty differ
      cnt_n = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (push) begin
         st_d.wr = st_q.wr + 1'b1;
      end
      if (pop) begin
         st_d.rd = st_q.rd + 1'b1;
      end
      st_d.cnt    = cnt_n;
      st_d.nfull  = cnt_n != (AW+1)'(DEPTH);
      st_d.nempty = cnt_n != '0;
   end

   // state register, reset to empty
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_q <= '{wr: '0, rd: '0, cnt: '0, nfull: 1'b1, nempty: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   // storage has no reset; only written entries are ever read
   // no bypass: a word shows one edge after its push
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[st_q.wr] <= in_data_i;
      end
   end

   assign in_ready_o  = st_q.nfull;
   assign out_valid_o = st_q.nempty;
   assign out_data_o  = mem_q[st_q.rd];
endmodule : sdme_fifo

// builds one 16-bit frame word {status nibble, fast data} per frame request; requests arriving while one waits share its word
module sdme_encoder #(
   parameter int FIFO_DEPTH_P = sdme_pkg::FIFO_DEPTH
) (
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic                    frame_req_i,       // one pulse per frame
   output logic                         frame_busy_o,      // request still waiting
   input  wire logic [11:0]             angle_i,           // angular value
   input  wire sdme_pkg::sdme_fmt_type  fmt_i,             // fast-channel format
   input  wire logic                    diag_mode_i,       // device in diagnostic mode
   input  wire logic                    angle_inv_fail_i,  // inverse angle check failed
   input  wire logic                    field_conv_fail_i, // field conversion check failed
   input  wire logic [8:0]              other_chk_fail_i,  // remaining checks, code bits 10:2
   input  wire logic                    oor_high_i,        // above out_of_range_limit high
   input  wire logic                    oor_low_i,         // below out_of_range_limit low
   input  wire logic                    memory_error_detect_i, // single-bit error corrected
   input  wire logic                    over_temp_i,       // temperature above threshold
   input  wire logic                    over_volt_i,       // supply above upper limit
   input  wire logic                    under_volt_i,      // supply below lower limit
   input  wire logic [9:0]              supply_meas_i,     // measured supply code
   input  wire logic [8:0]              temp_meas_i,       // measured temperature code
   input  wire logic                    slow_channel_enable_i, // from link_config_word_a
   input  wire logic                    mask_diag_i,       // from link_config_word_b
   input  wire logic                    mask_warn_i,       // from link_config_word_b
   input  wire logic [3:0]              app_class_i,       // application class field
   input  wire logic [1:0]              protocol_version_field_i,
   input  wire logic                    channel_index_bit_i,
   input  wire logic [11:0]             customer_word_i [8], // customer_word_1..8
   output logic                         word_valid_o,
   input  wire logic                    word_ready_i,
   output logic [15:0]                  word_o             // {status, data}
);
   import sdme_pkg::*;

   sdme_state_type st_q, st_d;        // encoder state
   logic [11:0]    safety_code;       // assembled safety error code
   logic [11:0]    diag_code;         // current diagnostic status code
   logic [11:0]    type_code;         // sensor type code
   logic [11:0]    rev_code;          // revision code
   logic [11:0]    msg_data_n;        // content for the next message
   logic [7:0]     msg_id_n;          // id for the next message
   logic [4:0]     msg_idx_n;         // message index for the next message
   logic [4:0]     msg_sel;           // message index whose content is chosen
   logic [3:0]     status;            // status nibble of this frame
   logic [11:0]    fast_data;         // data nibbles of this frame
   logic           prewarn;           // any pre-warning condition
   logic           bit3;              // serial sync/id bit
   logic           bit2;              // serial data bit
   logic           fifo_ready;        // fifo has room
   logic           emit;              // word written this cycle
   logic [4:0]     f;                 // frame index alias

   // safety code assembly, bit 11 marks diagnostic mode
   always_comb begin
      safety_code[11]   = diag_mode_i;
      safety_code[10:2] = other_chk_fail_i;
      safety_code[1]    = angle_inv_fail_i;
      safety_code[0]    = field_conv_fail_i;
   end

   // diagnostic status code, safety errors outrank pre-warnings
   // diagnostic mode by itself leaves the code at zero
   always_comb begin
      if (safety_code[10:0] != '0) begin
         diag_code = safety_code | 12'h800;
      end else if (oor_high_i) begin
         diag_code = DC_OOR_HI;
      end else if (oor_low_i) begin
         diag_code = DC_OOR_LO;
      end else if (under_volt_i) begin
         diag_code = DC_UNDERV;
      end else if (over_volt_i) begin
         diag_code = DC_OVERV;
      end else if (over_temp_i) begin
         diag_code = DC_OVERT;
      end else if (memory_error_detect_i) begin
         diag_code = DC_EDC;
      end else begin
         diag_code = DC_NONE;
      end
   end

   // sensor type and revision lookups
   always_comb begin
      unique case (app_class_i)
         4'h0: type_code = 12'h051;
         4'h1: type_code = 12'h052;
         4'h2: type_code = 12'h053;
         4'h3: type_code = 12'h054;
         4'h4: type_code = 12'h055;
         4'h5: type_code = 12'h056;
         4'h6: type_code = 12'h059;
         4'h7: type_code = 12'h05a;
         4'h8: type_code = 12'h062;
         4'h9: type_code = 12'h063;
         4'ha: type_code = 12'h064;
         4'hb: type_code = 12'h066;
         default: type_code = 12'h000;
      endcase
      unique case (protocol_version_field_i)
         2'b00: rev_code = 12'h000;
         2'b01: rev_code = 12'h002;
         2'b10: rev_code = 12'h003;
         default: rev_code = 12'h004;
      endcase
   end

   // next message id and content, chosen by position in the cycle
   always_comb begin
      msg_idx_n = (st_q.msg_idx == MSGS_PER_CYCLE - 5'd1) ? 5'd0 : st_q.msg_idx + 5'd1;
      // a disabled channel restarts at the first message
      if (!slow_channel_enable_i && emit) begin
         msg_sel = 5'd0;
      end else if (st_q.frame_idx == '0) begin
         msg_sel = st_q.msg_idx;
      end else begin
         msg_sel = msg_idx_n;
      end
      unique case (msg_sel)
         5'd0, 5'd7: msg_id_n = ID_DIAG;
         5'd1, 5'd8: msg_id_n = ID_TEMP;
         5'd2, 5'd9: msg_id_n = ID_SUPPLY;
         5'd3: msg_id_n = ID_TYPE;
         5'd4: msg_id_n = ID_CHAN;
         5'd5: msg_id_n = ID_MAKER;
         5'd6: msg_id_n = ID_REV;
         // customer words follow once the fixed messages are done
         default: msg_id_n = ID_CUST0 + 8'(msg_sel - 5'd10);
      endcase
      unique case (msg_id_n)
         ID_DIAG: msg_data_n = diag_code;
         ID_TEMP: msg_data_n = (temp_meas_i > 9'(TEMP_MAX)) ? TEMP_MAX : {3'h0, temp_meas_i};
         ID_SUPPLY: msg_data_n = (supply_meas_i > 10'(SUPPLY_MAX)) ? SUPPLY_MAX : {2'h0, supply_meas_i};
         ID_TYPE: msg_data_n = type_code;
         ID_CHAN: msg_data_n = channel_index_bit_i ? CHAN_CODE1 : CHAN_CODE0;
         ID_MAKER: msg_data_n = MAKER_CODE;
         ID_REV: msg_data_n = rev_code;
         default: msg_data_n = customer_word_i[3'(msg_id_n - ID_CUST0)];
      endcase
   end

   // serial bits of the current frame, enhanced 12-bit data format
   always_comb begin
      f = st_q.frame_idx;
      if (f < 5'd6) begin
         bit3 = 1'b1;
         bit2 = 1'b0;
      end else begin
         bit3 = 1'b0;
         bit2 = st_q.msg_data[4'(5'd17 - f)];
         if (f >= 5'd8 && f <= 5'd11) begin
            bit3 = st_q.msg_id[3'(5'd15 - f)];
         end else if (f >= 5'd13 && f <= 5'd16) begin
            bit3 = st_q.msg_id[3'(5'd16 - f)];
         end
      end
   end

   // status nibble and fast data of the current frame
   // content is sampled in the push cycle, not at the request
   always_comb begin
      // causes are levels; the flag drops once all have cleared
      prewarn = oor_high_i | oor_low_i | memory_error_detect_i | over_temp_i | over_volt_i | under_volt_i;
      status = 4'h0;
      status[ST_DIAG] = diag_mode_i & ~mask_diag_i;
      status[ST_WARN] = prewarn & ~diag_mode_i & ~mask_warn_i;
      status[ST_SER_DATA] = slow_channel_enable_i & bit2;
      status[ST_SER_SYNC] = slow_channel_enable_i & bit3;
      fast_data = angle_i;
      if (diag_mode_i) begin
         unique case (fmt_i)
            FMT_A1: fast_data = FAST_DIAG_A1;
            FMT_H1, FMT_H3, FMT_H4: fast_data = FAST_DIAG_H;
            default: fast_data = angle_i;
         endcase
      end
   end

   // request tracking and frame/message stepping
   always_comb begin
      st_d = st_q;
      emit = st_q.pending & fifo_ready;
      // a request that arrives while one waits is folded into it
      if (frame_req_i) begin
         st_d.pending = 1'b1;
      end
      if (emit) begin
         st_d.pending = frame_req_i;
         if (!slow_channel_enable_i) begin
            // disabled channel restarts the cycle from its first message
            st_d.frame_idx = '0;
            st_d.msg_idx   = '0;
         end else if (st_q.frame_idx == FRAMES_PER_MSG - 5'd1) begin
            st_d.frame_idx = '0;
            st_d.msg_idx   = msg_idx_n;
         end else begin
            st_d.frame_idx = st_q.frame_idx + 5'd1;
         end
      end
      // content is latched for the whole message so its bits stay coherent
      if (st_d.frame_idx == '0 && (emit || st_q.frame_idx == '0)) begin
         st_d.msg_id   = msg_id_n;
         st_d.msg_data = msg_data_n;
      end
   end

   // state register
   always_ff @(posedge ref_clk_i) begin
      if (!rst_b_i) begin
         st_q <= '{pending: 1'b0, frame_idx: '0, msg_idx: '0, msg_id: ID_DIAG, msg_data: DC_NONE};
      end else begin
         st_q <= st_d;
      end
   end

   // busy is the pending flop itself, so the port comes from a flop
   assign frame_busy_o = st_q.pending;

   // frame words queue toward the nibble serialiser, which adds the crc
   // status nibble kept out of the crc
   sdme_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH_P)) u_fifo (
      .ref_clk_i   (ref_clk_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (emit),
      .in_ready_o  (fifo_ready),
      .in_data_i   ({status, fast_data}),
      .out_valid_o (word_valid_o),
      .out_ready_i (word_ready_i),
      .out_data_o  (word_o)
   );

   // checks run on the core clock and sleep while reset is low
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence emit_s;
      emit;
   endsequence

   diag_flag_a: assert property (emit_s |-> status[ST_DIAG] == (diag_mode_i & ~mask_diag_i))
      else $error("diagnostic flag wrong");
   diag_mask_a: assert property (mask_diag_i |-> !status[ST_DIAG])
      else $error("masked diagnostic flag set");
   warn_normal_a: assert property (diag_mode_i |-> !status[ST_WARN])
      else $error("pre-warning in diagnostic mode");
   warn_mask_a: assert property (mask_warn_i |-> !status[ST_WARN])
      else $error("masked pre-warning set");
   fast_a1_a: assert property (diag_mode_i && fmt_i == FMT_A1 |-> fast_data == 12'd4095)
      else $error("a1 diagnostic value wrong");
   fast_angle_a: assert property (!diag_mode_i |-> fast_data == angle_i)
      else $error("angle not sent");
   slow_off_a: assert property (!slow_channel_enable_i |-> status[3:2] == 2'b00)
      else $error("serial bits while disabled");
   frame_wrap_a: assert property (emit && slow_channel_enable_i && st_q.frame_idx == 5'd17
      |=> st_q.frame_idx == 5'd0)
      else $error("message not 18 frames");
   sync_run_a: assert property (emit && slow_channel_enable_i && st_q.frame_idx == 5'd0
      |-> status[ST_SER_SYNC])
      else $error("sync bit missing");
   cycle_wrap_a: assert property (emit && slow_channel_enable_i && st_q.frame_idx == 5'd17
      && st_q.msg_idx == 5'd17 |=> st_q.msg_idx == 5'd0 && st_q.msg_id == ID_DIAG)
      else $error("cycle does not restart");
   temp_clamp_a: assert property (msg_id_n == ID_TEMP |-> msg_data_n <= 12'h0ff)
      else $error("temperature code reserved");
   type_resv_a: assert property (app_class_i == 4'hc |-> type_code == 12'h000)
      else $error("class 1100b not reserved");
   safety_bits_a: assert property (angle_inv_fail_i || field_conv_fail_i
      |-> diag_code[11] && diag_code[1:0] == {angle_inv_fail_i, field_conv_fail_i})
      else $error("safety code bits wrong");
   chan_code_a: assert property (msg_id_n == ID_CHAN |-> msg_data_n == {12{channel_index_bit_i}})
      else $error("channel index code wrong");
   supply_clamp_a: assert property (msg_id_n == ID_SUPPLY |-> msg_data_n <= 12'h1ff)
      else $error("supply code reserved");
   fast_h_a: assert property (diag_mode_i && fmt_i inside {FMT_H1, FMT_H3, FMT_H4}
      |-> fast_data == 12'd4090)
      else $error("h diagnostic value wrong");
   msg_hold_a: assert property (emit && slow_channel_enable_i && st_q.frame_idx < 5'd17
      |=> $stable(st_q.msg_id) && $stable(st_q.msg_data))
      else $error("message changed mid-way");
endmodule : sdme_encoder

`default_nettype wire

// ---- tb/sdme_sent_rx.sv ----
`timescale 1ns/1ps
`default_nettype none

// far-side receiver: drains frame words and rebuilds slow-channel messages
module sdme_sent_rx (
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        stall_i,      // hold off draining
   input  wire logic        word_valid_i,
   input  wire logic [15:0] word_i,
   output logic             word_ready_o,
   output logic [15:0]      last_word_o,  // last frame taken
   output logic [15:0]      word_cnt_o,
   output logic             msg_stb_o,    // one-cycle message pulse
   output logic [7:0]       msg_id_o,
   output logic [11:0]      msg_data_o,
   output logic [15:0]      msg_cnt_o
);
   logic [17:0] s15_q;  // bit15 history, newest in bit 0
   logic [17:0] s14_q;  // bit14 history
   logic [17:0] n15;
   logic [17:0] n14;
   logic        take;
   assign take = word_valid_i & word_ready_o;
   assign n15  = {s15_q[16:0], word_i[15]};
   assign n14  = {s14_q[16:0], word_i[14]};
   // ready is registered, so a stall lands one edge late as in a real sink
   always_ff @(posedge ref_clk_i) begin
      msg_stb_o <= 1'b0;
      if (!rst_b_i) begin
         word_ready_o <= 1'b0;
         s15_q        <= '0;
         s14_q        <= '0;
         word_cnt_o   <= '0;
         msg_cnt_o    <= '0;
      end else begin
         word_ready_o <= !stall_i;
         if (take) begin
            last_word_o <= word_i;
            word_cnt_o  <= word_cnt_o + 16'h1;
            s15_q       <= n15;
            s14_q       <= n14;
            if (n15[17:12] == 6'h3f && n15[11:10] == 2'b00 && !n15[5] && !n15[0]) begin
               msg_stb_o  <= 1'b1;
               msg_id_o   <= {n15[9:6], n15[4:1]};
               msg_data_o <= n14[11:0];
               msg_cnt_o  <= msg_cnt_o + 16'h1;
            end
         end
      end
   end
endmodule : sdme_sent_rx

`default_nettype wire

// ---- tb/sdme_encoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module sdme_encoder_tb;
   import sdme_pkg::*;
   logic         ref_clk_i = 1'b0;
   logic         rst_b_i = 1'b0;
   logic         frame_req_i = 1'b0;
   logic         frame_busy_o;
   logic [11:0]  angle_i = 12'h3a5;
   sdme_fmt_type fmt_i = FMT_A1;
   logic         diag_mode_i = 1'b0;
   logic [10:0]  safety = '0;  // {other checks, inverse angle, field}
   logic [5:0]   warn = '0;    // oor hi, oor lo, under, over, temp, edc
   logic [9:0]   supply_meas_i = '0;
   logic [8:0]   temp_meas_i = '0;
   logic         slow_channel_enable_i = 1'b0;
   logic         mask_diag_i = 1'b0;
   logic         mask_warn_i = 1'b0;
   logic [3:0]   app_class_i = '0;
   logic [1:0]   protocol_version_field_i = '0;
   logic         channel_index_bit_i = 1'b0;
   logic [11:0]  customer_word_i [8] = '{default: '0};
   logic         word_valid_o, word_ready_i, msg_stb, stall = 1'b0;
   logic [15:0]  word_o, last_word, word_cnt, msg_cnt, n0;
   logic [7:0]   msg_id;
   logic [11:0]  msg_data;
   int           num_errors = 0, checks_done = 0, cyc = 0;
   logic [7:0]   id_tab [18] = '{8'h01, 8'h23, 8'h1c, 8'h03, 8'h29, 8'h05, 8'h06, 8'h01, 8'h23,
                                 8'h1c, 8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97};
   logic [11:0]  app_tab [16] = '{12'h051, 12'h052, 12'h053, 12'h054, 12'h055, 12'h056, 12'h059,
                                  12'h05a, 12'h062, 12'h063, 12'h064, 12'h066, 12'h000, 12'h000,
                                  12'h000, 12'h000};
   logic [11:0]  ver_tab [4] = '{12'h000, 12'h002, 12'h003, 12'h004};
   logic [11:0]  st_tab [6] = '{12'h001, 12'h002, 12'h020, 12'h021, 12'h022, 12'h023};

   sdme_encoder u_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .frame_req_i(frame_req_i),
      .frame_busy_o(frame_busy_o), .angle_i(angle_i), .fmt_i(fmt_i), .diag_mode_i(diag_mode_i),
      .angle_inv_fail_i(safety[1]), .field_conv_fail_i(safety[0]), .other_chk_fail_i(safety[10:2]),
      .oor_high_i(warn[0]), .oor_low_i(warn[1]), .under_volt_i(warn[2]), .over_volt_i(warn[3]),
      .over_temp_i(warn[4]), .memory_error_detect_i(warn[5]), .supply_meas_i(supply_meas_i),
      .temp_meas_i(temp_meas_i), .slow_channel_enable_i(slow_channel_enable_i),
      .mask_diag_i(mask_diag_i), .mask_warn_i(mask_warn_i), .app_class_i(app_class_i),
      .protocol_version_field_i(protocol_version_field_i), .channel_index_bit_i(channel_index_bit_i),
      .customer_word_i(customer_word_i), .word_valid_o(word_valid_o), .word_ready_i(word_ready_i),
      .word_o(word_o));
   sdme_sent_rx u_rx (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .stall_i(stall),
      .word_valid_i(word_valid_o), .word_i(word_o), .word_ready_o(word_ready_i),
      .last_word_o(last_word), .word_cnt_o(word_cnt), .msg_stb_o(msg_stb), .msg_id_o(msg_id),
      .msg_data_o(msg_data), .msg_cnt_o(msg_cnt));

   always #50 ref_clk_i = ~ref_clk_i;

   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : results

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // one request with an empty fifo, then the word the receiver took
   task automatic frame(output logic [15:0] w);
      n0 = word_cnt;
      @(posedge ref_clk_i) frame_req_i <= 1'b1;
      @(posedge ref_clk_i) frame_req_i <= 1'b0;
      #1 chk("busy while pending", 16'h1, {15'h0, frame_busy_o});
      @(posedge ref_clk_i);
      #1 chk("valid after push", 16'h2, {14'h0, word_valid_o, frame_busy_o});
      for (int i = 0; i < 8 && word_cnt == n0; i++) begin
         @(posedge ref_clk_i);
         #1;
      end
      w = last_word;
   endtask : frame

   // expected message content, from the bench's own copy of the inputs
   function automatic logic [11:0] exp_data(input logic [7:0] id);
      exp_data = 12'h000;
      case (id)
         8'h01: begin
            if (safety != 11'h0) exp_data = {1'b1, safety};
            else for (int i = 5; i >= 0; i--) if (warn[i]) exp_data = st_tab[i];
         end
         8'h23: exp_data = (temp_meas_i > 9'h0ff) ? 12'h0ff : {3'h0, temp_meas_i};
         8'h1c: exp_data = (supply_meas_i > 10'h1ff) ? 12'h1ff : {2'h0, supply_meas_i};
         8'h03: exp_data = app_tab[app_class_i];
         8'h29: exp_data = {12{channel_index_bit_i}};
         8'h05: exp_data = MAKER_CODE;
         8'h06: exp_data = ver_tab[protocol_version_field_i];
         default: exp_data = customer_word_i[id[2:0]];
      endcase
   endfunction : exp_data

   // every decoded message against the schedule and the inputs
   always @(posedge ref_clk_i) begin
      cyc++;
      if (msg_stb) begin
         chk("message id", {8'h0, id_tab[(msg_cnt - 16'h1) % 18]}, {8'h0, msg_id});
         chk("message data", {4'h0, exp_data(msg_id)}, {4'h0, msg_data});
      end
      if (cyc == 20000) begin
         num_errors++;
         results();
      end
   end

   initial begin
      logic [15:0] w;
      logic [11:0] ed;
      repeat (6) @(posedge ref_clk_i);
      #1 chk("flags in reset", 16'h0, {14'h0, word_valid_o, frame_busy_o});
      @(posedge ref_clk_i) rst_b_i <= 1'b1;
      // fast data and diagnostic flag over every format
      for (int f = 0; f < 5; f++) begin
         for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk_i);
            fmt_i <= sdme_fmt_type'(5'b00001 << f);
            diag_mode_i <= d[0];
            frame(w);
            ed = (d == 0 || f == 1) ? angle_i : (f == 0) ? FAST_DIAG_A1 : FAST_DIAG_H;
            chk("fast data", {4'h0, ed}, {4'h0, w[11:0]});
            chk("status nibble", {15'h0, d[0]}, {12'h0, w[15:12]});
         end
      end
      // each pre-warning cause, then all of them masked
      for (int k = 0; k < 7; k++) begin
         @(posedge ref_clk_i);
         diag_mode_i <= 1'b0;
         warn <= (k < 6) ? 6'h1 << k : 6'h3f;
         mask_warn_i <= (k == 6);
         frame(w);
         chk("warn bit", {15'h0, k < 6}, {15'h0, w[13]});
      end
      @(posedge ref_clk_i);
      warn <= 6'h01;
      mask_warn_i <= 1'b0;
      mask_diag_i <= 1'b1;
      diag_mode_i <= 1'b1;
      fmt_i <= FMT_H1;
      frame(w);
      chk("masked diag", {4'h0, FAST_DIAG_H}, w);
      // fill the fifo with the receiver stalled, then drain it
      @(posedge ref_clk_i);
      stall <= 1'b1;
      diag_mode_i <= 1'b0;
      mask_diag_i <= 1'b0;
      n0 = word_cnt;
      repeat (18) @(posedge ref_clk_i) frame_req_i <= 1'b1;
      @(posedge ref_clk_i) frame_req_i <= 1'b0;
      repeat (2) @(posedge ref_clk_i);
      #1 chk("busy when full", 16'h1, {15'h0, frame_busy_o});
      @(posedge ref_clk_i) stall <= 1'b0;
      repeat (30) @(posedge ref_clk_i);
      #1 chk("words after full", n0 + 16'd17, word_cnt);
      chk("drained", 16'h0, {15'h0, word_valid_o});
      chk("no messages while off", 16'h0, msg_cnt);
      // sixteen full message cycles with varied settings
      for (int c = 0; c < 16; c++) begin
         @(posedge ref_clk_i);
         slow_channel_enable_i <= 1'b1;
         app_class_i <= c[3:0];
         protocol_version_field_i <= c[1:0];
         channel_index_bit_i <= c[0];
         supply_meas_i <= {c[3:0], 6'h15};
         temp_meas_i <= {c[3:0], 5'h0a};
         for (int k = 0; k < 8; k++) customer_word_i[k] <= (k == 0) ? 12'h000 : (k == 7) ? 12'hfff : {c[3:0], k[3:0], 4'h5};
         warn <= (c >= 1 && c <= 6) ? 6'h1 << (c - 1) : (c == 9) ? 6'h07 : (c == 10) ? 6'h20 : 6'h0;
         safety <= (c == 7 || c == 10) ? 11'h2 : (c == 8) ? 11'h1 : (c == 11) ? 11'h7ff : 11'h0;
         repeat (324) @(posedge ref_clk_i) frame_req_i <= 1'b1;
         @(posedge ref_clk_i) frame_req_i <= 1'b0;
         for (int i = 0; i < 50 && msg_cnt != 18 * (c + 1); i++) begin
            @(posedge ref_clk_i);
            #1;
         end
         chk("message count", 16'(18 * (c + 1)), msg_cnt);
      end
      results();
   end
endmodule : sdme_encoder_tb

`default_nettype wire
